// ==== hdl/pbm_port_bank.sv ====
`timescale 1ns/1ns
// Overview of operation
// [R1] each bidirectional port pin has a direction bit, 1 output, reset 0
// [R2] each bidirectional port pin has a data bit, reset 1
// [R3] groups 0 and 1 float per nibble, bit set floats, reset 0
// [R4] group 2 pins each have a float bit, reset 0
// [R5] group 3 pins each have a float bit, reset 0
// [R6] group 5 float bits at bits 7,6; bits 5,4 spare storage
// [R7] groups 0 to 3 output data bits, reset 1
// [R8] group 5 data in bits 1,0 reset 1,0; upper bits read 0
// [R9] mode 11 512K max, 10 512K min, 01 64K, 00 single chip
// [R10] mode 00 is single chip only from internal program memory
// [R11] internal program operation resets into single chip mode
// [R12] external program operation resets into the strapped expanded mode
// [R13] software from internal memory sets expanded mode at start-up
// [R14] software picks the bus mode to fit external memory size
// [R15] expanded modes: groups 0,1 address A0-A15; 512K adds A16-A18
// [R16] expanded modes: group 2 pins 3,4 strobes, port 0 data bus
// [R17] eight spare storage bits reset to 1
// [R18] unused external program: strap recommended 512K maximum
// [R19] output port pin drives its data; input pin reads its level
// [R20] pins taken by the bus ignore port data, direction and float
module pbm_port_bank #(
   parameter logic [1:0] MASK_MODE = 2'h3
) (
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [15:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        ext_prog_in,
   input  wire logic [7:0]  port0_pin_in,
   input  wire logic [7:0]  port1_pin_in,
   output logic      [7:0]  port0_out,
   output logic      [7:0]  port0_oe_out,
   output logic      [7:0]  port1_out,
   output logic      [7:0]  port1_oe_out,
   output logic      [31:0] rout_out,
   output logic      [31:0] rout_oe_out,
   output logic      [1:0]  grp5_out,
   output logic      [1:0]  grp5_oe_out,
   output logic      [1:0]  mode_out
);
   // ********************************
   // pin synchronisers and strap
   // ********************************
   logic [7:0] p0_meta_ff, p0_sync_ff, p1_meta_ff, p1_sync_ff;
   logic       ext_meta_ff, ext_sync_ff;
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         p0_meta_ff  <= 8'h00;
         p0_sync_ff  <= 8'h00;
         p1_meta_ff  <= 8'h00;
         p1_sync_ff  <= 8'h00;
         ext_meta_ff <= 1'b0;
         ext_sync_ff <= 1'b0;
      end else begin
         p0_meta_ff  <= port0_pin_in;
         p0_sync_ff  <= p0_meta_ff;
         p1_meta_ff  <= port1_pin_in;
         p1_sync_ff  <= p1_meta_ff;
         ext_meta_ff <= ext_prog_in;
         ext_sync_ff <= ext_meta_ff;
      end
   end

   // strap is latched once after reset release, then held
   logic [1:0] boot_ff;
   logic       strap_done_ff;
   logic [1:0] strap_cnt_ff;
   logic       ext_prog_ff;
   // ********************************
   // registers
   // ********************************
   logic [7:0] dir0_ff, dir1_ff, dat0_ff, dat1_ff;
   logic [7:0] flt_a_ff, flt2_ff, flt3_ff;
   logic [7:0] r0_ff, r1_ff, r2_ff, r3_ff, spare_ff, r5_ff;
   logic [1:0] mode_sel_ff;
   logic [18:0] ext_addr_ff;
   logic [7:0]  ext_wdata_ff;
   logic [2:0]  ext_ctrl_ff;
   logic [7:0]  ext_rdata_ff;
   pbm_pkg::pbm_mode_type eff_mode;
   logic expanded, big;
   logic wr_en, rd_en;

   assign wr_en = psel_in & penable_in & pwrite_in;
   assign rd_en = psel_in & penable_in & ~pwrite_in;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         strap_cnt_ff  <= 2'h0;
         strap_done_ff <= 1'b0;
         ext_prog_ff   <= 1'b0;
      end else if (!strap_done_ff) begin
         // the synchroniser still holds its reset value for two edges
         strap_cnt_ff <= strap_cnt_ff + 2'h1;
         if (strap_cnt_ff == pbm_pkg::STRAP_WAIT) begin
            strap_done_ff <= 1'b1;
            ext_prog_ff   <= ext_sync_ff;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         dir0_ff  <= pbm_pkg::RST_DIR; // R1
         dir1_ff  <= pbm_pkg::RST_DIR; // R1
         dat0_ff  <= pbm_pkg::RST_DATA; // R2
         dat1_ff  <= pbm_pkg::RST_DATA; // R2
         flt_a_ff <= pbm_pkg::RST_FLOAT; // R3
         flt2_ff  <= pbm_pkg::RST_FLOAT; // R4
         flt3_ff  <= pbm_pkg::RST_FLOAT; // R5
         r0_ff    <= pbm_pkg::RST_DATA; // R7
         r1_ff    <= pbm_pkg::RST_DATA; // R7
         r2_ff    <= pbm_pkg::RST_DATA; // R7
         r3_ff    <= pbm_pkg::RST_DATA; // R7
         spare_ff <= pbm_pkg::RST_DATA; // R17
         r5_ff    <= pbm_pkg::RST_GRP5; // R8
         mode_sel_ff  <= pbm_pkg::PBM_SINGLE; // R11
         ext_addr_ff  <= 19'h00000;
         ext_wdata_ff <= 8'h00;
         ext_ctrl_ff  <= 3'h0;
      end else if (wr_en) begin
         case (paddr_in)
            pbm_pkg::ADDR_PORT0_DIR:  dir0_ff  <= pwdata_in[7:0]; // R1
            pbm_pkg::ADDR_PORT1_DIR:  dir1_ff  <= pwdata_in[7:0]; // R1
            pbm_pkg::ADDR_PORT0_DATA: dat0_ff  <= pwdata_in[7:0]; // R2
            pbm_pkg::ADDR_PORT1_DATA: dat1_ff  <= pwdata_in[7:0]; // R2
            pbm_pkg::ADDR_FLOAT_A:    flt_a_ff <= pwdata_in[7:0]; // R3 R6
            pbm_pkg::ADDR_FLOAT_GRP2: flt2_ff  <= pwdata_in[7:0]; // R4
            pbm_pkg::ADDR_FLOAT_GRP3: flt3_ff  <= pwdata_in[7:0]; // R5
            pbm_pkg::ADDR_GRP0_DATA:  r0_ff    <= pwdata_in[7:0]; // R7
            pbm_pkg::ADDR_GRP1_DATA: begin
               r1_ff <= pwdata_in[7:0]; // R7
            end
            pbm_pkg::ADDR_GRP2_DATA: begin
               r2_ff <= pwdata_in[7:0]; // R7
            end
            pbm_pkg::ADDR_GRP3_DATA: begin
               r3_ff <= pwdata_in[7:0]; // R7
            end
            pbm_pkg::ADDR_RESERVED: begin
               spare_ff <= pwdata_in[7:0]; // R17
            end
            pbm_pkg::ADDR_GRP5_DATA: begin
               r5_ff <= pwdata_in[7:0] & pbm_pkg::GRP5_MASK; // R8
            end
            pbm_pkg::ADDR_BUS_MODE: begin
               mode_sel_ff <= pwdata_in[1:0]; // R9
            end
            pbm_pkg::ADDR_EXT_ADDR: begin
               ext_addr_ff <= pwdata_in[18:0];
            end
            pbm_pkg::ADDR_EXT_CTRL: begin
               ext_ctrl_ff  <= pwdata_in[2:0];
               ext_wdata_ff <= pwdata_in[15:8];
            end
            default: begin
            end
         endcase
      end
   end

   // ********************************
   // mode decode
   // ********************************
   always_comb begin
      if (!strap_done_ff) begin
         eff_mode = pbm_pkg::PBM_SINGLE;
      end else if (mode_sel_ff == 2'h0 && ext_prog_ff) begin
         eff_mode = pbm_pkg::pbm_mode_type'(MASK_MODE); // R10 R12
      end else begin
         eff_mode = pbm_pkg::pbm_mode_type'(mode_sel_ff); // R9
      end
   end
   assign expanded = (eff_mode != pbm_pkg::PBM_SINGLE);
   assign big = (eff_mode == pbm_pkg::PBM_EXP512N)
              | (eff_mode == pbm_pkg::PBM_EXP512X);

   // ********************************
   // pin drive
   // ********************************
   pbm_pkg::pbm_ext_type ext;
   logic [31:0] nxt_rout, nxt_rout_oe;
   logic [7:0]  flt0, flt1;
   assign ext = '{addr: ext_addr_ff, wdata: ext_wdata_ff,
                  rd: ext_ctrl_ff[pbm_pkg::EXT_CTRL_RD_BIT],
                  wr: ext_ctrl_ff[pbm_pkg::EXT_CTRL_WR_BIT],
                  doe: ext_ctrl_ff[pbm_pkg::EXT_CTRL_DOE_BIT]};
   assign flt0 = {{4{flt_a_ff[1]}}, {4{flt_a_ff[0]}}}; // R3
   assign flt1 = {{4{flt_a_ff[3]}}, {4{flt_a_ff[2]}}}; // R3

   always_comb begin
      nxt_rout    = {r3_ff, r2_ff, r1_ff, r0_ff}; // R7
      nxt_rout_oe = ~{flt3_ff, flt2_ff, flt1, flt0}; // R4 R5
      if (expanded) begin
         // bus owned pins always drive, float bits ignored
         nxt_rout[15:0]    = ext.addr[15:0]; // R15 R20
         nxt_rout_oe[15:0] = 16'hFFFF; // R20
         nxt_rout[19]      = ~ext.rd; // R16
         nxt_rout[20]      = ~ext.wr; // R16
         nxt_rout_oe[20:19] = 2'h3; // R20
      end
      if (big) begin
         nxt_rout[18:16]    = ext.addr[18:16]; // R15
         nxt_rout_oe[18:16] = 3'h7; // R20
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rout_out     <= 32'hFFFFFFFF;
         rout_oe_out  <= 32'hFFFFFFFF;
         grp5_out     <= 2'h2;
         grp5_oe_out  <= 2'h3;
         port0_out    <= 8'hFF;
         port0_oe_out <= 8'h00;
         port1_out    <= 8'hFF;
         port1_oe_out <= 8'h00;
         mode_out     <= 2'h0;
         ext_rdata_ff <= 8'h00;
      end else begin
         rout_out    <= nxt_rout;
         rout_oe_out <= nxt_rout_oe;
         grp5_out    <= r5_ff[1:0]; // R8
         grp5_oe_out <= ~{flt_a_ff[pbm_pkg::GRP5_P1_FLOAT_BIT],
                          flt_a_ff[pbm_pkg::GRP5_P0_FLOAT_BIT]}; // R6
         port1_out    <= dat1_ff; // R19
         port1_oe_out <= dir1_ff; // R19
         mode_out     <= eff_mode;
         if (expanded) begin
            port0_out    <= ext.wdata; // R16 R20
            port0_oe_out <= {8{ext.doe}}; // R16 R20
            ext_rdata_ff <= p0_sync_ff;
         end else begin
            port0_out    <= dat0_ff; // R19
            port0_oe_out <= dir0_ff; // R19
         end
      end
   end

   // ********************************
   // apb read side
   // ********************************
   logic [7:0] rd_mux;
   logic       hit;
   always_comb begin
      hit = 1'b1;
      case (paddr_in)
         pbm_pkg::ADDR_PORT0_DIR:  rd_mux = dir0_ff;
         pbm_pkg::ADDR_PORT1_DIR:  rd_mux = dir1_ff;
         // input pins read their level, outputs their latch
         pbm_pkg::ADDR_PORT0_DATA:
            rd_mux = (dir0_ff & dat0_ff) | (~dir0_ff & p0_sync_ff); // R19
         pbm_pkg::ADDR_PORT1_DATA:
            rd_mux = (dir1_ff & dat1_ff) | (~dir1_ff & p1_sync_ff); // R19
         pbm_pkg::ADDR_FLOAT_A:    rd_mux = flt_a_ff;
         pbm_pkg::ADDR_FLOAT_GRP2: rd_mux = flt2_ff;
         pbm_pkg::ADDR_FLOAT_GRP3: rd_mux = flt3_ff;
         pbm_pkg::ADDR_GRP0_DATA:  rd_mux = r0_ff;
         pbm_pkg::ADDR_GRP1_DATA:  rd_mux = r1_ff;
         pbm_pkg::ADDR_GRP2_DATA:  rd_mux = r2_ff;
         pbm_pkg::ADDR_GRP3_DATA:  rd_mux = r3_ff;
         pbm_pkg::ADDR_RESERVED:   rd_mux = spare_ff;
         pbm_pkg::ADDR_GRP5_DATA:  rd_mux = r5_ff & pbm_pkg::GRP5_MASK; // R8
         pbm_pkg::ADDR_BUS_MODE:   rd_mux = {6'h00, mode_sel_ff};
         pbm_pkg::ADDR_EXT_CTRL:   rd_mux = ext_rdata_ff;
         default: begin
            rd_mux = 8'h00;
            hit    = (paddr_in == pbm_pkg::ADDR_EXT_ADDR);
         end
      endcase
   end

   // answer registered at setup, so it stands through the access phase
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         prdata_out  <= 32'h00000000;
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         pready_out  <= psel_in & ~penable_in;
         pslverr_out <= psel_in & ~penable_in & ~hit;
         if (psel_in & ~penable_in & ~pwrite_in) begin
            prdata_out <= {24'h000000, rd_mux};
         end
      end
   end

   // ********************************
   // checks
   // ********************************
   property p_mode_reset;
      @(posedge clk_in) disable iff (!rstn_in)
      $rose(strap_done_ff) && !ext_prog_ff |=> mode_out == 2'h0;
   endproperty
   a_mode_reset: assert property (p_mode_reset) // R11
      else $error("internal program did not start in single chip");

   property p_strap_mode;
      @(posedge clk_in) disable iff (!rstn_in)
      strap_done_ff && ext_prog_ff && mode_sel_ff == 2'h0
      |=> mode_out == MASK_MODE;
   endproperty
   a_strap_mode: assert property (p_strap_mode) // R12
      else $error("external program mode 00 not mapped to strap mode");

   property p_addr_drive;
      @(posedge clk_in) disable iff (!rstn_in)
      expanded |=> rout_out[15:0] == $past(ext.addr[15:0])
                   && rout_oe_out[15:0] == 16'hFFFF;
   endproperty
   a_addr_drive: assert property (p_addr_drive) // R15
      else $error("address lines not driven in expanded mode");

   property p_hi_addr;
      @(posedge clk_in) disable iff (!rstn_in)
      !big |=> rout_out[18:16] == $past(r2_ff[2:0]);
   endproperty
   a_hi_addr: assert property (p_hi_addr) // R15
      else $error("group 2 low pins not port outside 512K");

   property p_strobe;
      @(posedge clk_in) disable iff (!rstn_in)
      expanded && ext.rd |=> rout_out[19] == 1'b0;
   endproperty
   a_strobe: assert property (p_strobe) // R16
      else $error("read strobe not active low");

   property p_port_dir;
      @(posedge clk_in) disable iff (!rstn_in)
      !expanded |=> port0_oe_out == $past(dir0_ff)
                    && port0_out == $past(dat0_ff);
   endproperty
   a_port_dir: assert property (p_port_dir) // R19
      else $error("port 0 does not follow direction and data");

   property p_nibble;
      @(posedge clk_in) disable iff (!rstn_in)
      !expanded && flt_a_ff[0] |=> rout_oe_out[3:0] == 4'h0;
   endproperty
   a_nibble: assert property (p_nibble) // R3
      else $error("group 0 low nibble not floated");

   property p_grp5_float;
      @(posedge clk_in) disable iff (!rstn_in)
      flt_a_ff[7] |=> !grp5_oe_out[1];
   endproperty
   a_grp5_float: assert property (p_grp5_float) // R6
      else $error("group 5 pin 1 not floated");

   property p_grp5_upper;
      @(posedge clk_in) disable iff (!rstn_in)
      psel_in && !penable_in && !pwrite_in
      && paddr_in == pbm_pkg::ADDR_GRP5_DATA |=> prdata_out[7:2] == 6'h00;
   endproperty
   a_grp5_upper: assert property (p_grp5_upper) // R8
      else $error("group 5 upper bits not zero");
endmodule

// ==== inc/pbm_pkg.sv ====
package pbm_pkg;
   // ********************************
   // register byte addresses
   // ********************************
   localparam logic [15:0] ADDR_PORT0_DIR      = 16'hFF60;
   localparam logic [15:0] ADDR_PORT1_DIR      = 16'hFF61;
   localparam logic [15:0] ADDR_PORT0_DATA     = 16'hFF62;
   localparam logic [15:0] ADDR_PORT1_DATA     = 16'hFF63;
   localparam logic [15:0] ADDR_FLOAT_A        = 16'hFF70;
   localparam logic [15:0] ADDR_FLOAT_GRP2     = 16'hFF71;
   localparam logic [15:0] ADDR_FLOAT_GRP3     = 16'hFF72;
   localparam logic [15:0] ADDR_GRP0_DATA      = 16'hFF73;
   localparam logic [15:0] ADDR_GRP1_DATA      = 16'hFF74;
   localparam logic [15:0] ADDR_GRP2_DATA      = 16'hFF75;
   localparam logic [15:0] ADDR_GRP3_DATA      = 16'hFF76;
   localparam logic [15:0] ADDR_RESERVED       = 16'hFF77;
   localparam logic [15:0] ADDR_GRP5_DATA      = 16'hFF78;
   localparam logic [15:0] ADDR_BUS_MODE       = 16'hFF7C;
   localparam logic [15:0] ADDR_EXT_ADDR       = 16'hFF80;
   localparam logic [15:0] ADDR_EXT_CTRL       = 16'hFF84;
   // ********************************
   // reset values
   // ********************************
   localparam logic [7:0] RST_DIR       = 8'h00;
   localparam logic [7:0] RST_DATA      = 8'hFF;
   localparam logic [7:0] RST_FLOAT     = 8'h00;
   localparam logic [7:0] RST_GRP5      = 8'h02;
   localparam logic [7:0] GRP5_MASK     = 8'h03;
   // strap is taken once it has crossed both synchroniser stages
   localparam logic [1:0] STRAP_WAIT    = 2'h2;
   // ********************************
   // field positions
   // ********************************
   localparam int GRP5_P1_FLOAT_BIT = 7;
   localparam int GRP5_P0_FLOAT_BIT = 6;
   localparam int EXT_CTRL_RD_BIT   = 0;
   localparam int EXT_CTRL_WR_BIT   = 1;
   localparam int EXT_CTRL_DOE_BIT  = 2;
   // ********************************
   // bus modes
   // ********************************
   typedef enum logic [1:0] {
      PBM_SINGLE  = 2'h0,
      PBM_EXP64   = 2'h1,
      PBM_EXP512N = 2'h2,
      PBM_EXP512X = 2'h3
   } pbm_mode_type;
   typedef struct packed {
      logic [18:0] addr;
      logic [7:0]  wdata;
      logic        rd;
      logic        wr;
      logic        doe;
   } pbm_ext_type;
endpackage

// ==== sim/pbm_pins_model.sv ====
`timescale 1ns/1ns
// ****************************************
// board pins and a one-byte external memory
// ****************************************
module pbm_pins_model (
   input  wire logic [7:0]  port0_out_in,
   input  wire logic [7:0]  port0_oe_in,
   input  wire logic [7:0]  port1_out_in,
   input  wire logic [7:0]  port1_oe_in,
   input  wire logic [31:0] rout_in,
   input  wire logic [15:0] board_in,
   output logic      [7:0]  port0_pin_out,
   output logic      [7:0]  port1_pin_out
);
   logic [7:0] mem_ff;
   // memory latches the data bus as the write strobe returns high
   always @(posedge rout_in[20]) begin
      mem_ff <= port0_pin_out;
   end
   // the memory only drives while the read strobe is low
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         port0_pin_out[i] = port0_oe_in[i] ? port0_out_in[i] :
            (rout_in[19] === 1'h0) ? mem_ff[i] : board_in[i];
         port1_pin_out[i] = port1_oe_in[i] ? port1_out_in[i] :
            board_in[8+i];
      end
   end
endmodule

// ==== sim/port_bank_bus_mode_pinmux_tb.sv ====
`timescale 1ns/1ns
module port_bank_bus_mode_pinmux_tb;
   logic        clk_in      = 1'h0;
   logic        rstn_in     = 1'h0;
   logic        psel_in     = 1'h0;
   logic        penable_in  = 1'h0;
   logic        pwrite_in   = 1'h0;
   logic [15:0] paddr_in    = 16'h0;
   logic [31:0] pwdata_in   = 32'h0;
   logic        ext_prog_in = 1'h0;
   logic [15:0] board_lvl   = 16'hFFFF;
   logic [31:0] prdata_out, rout_out, rout_oe_out;
   logic        pready_out, pslverr_out;
   logic [7:0]  port0_pin_in, port1_pin_in, port0_out, port0_oe_out;
   logic [7:0]  port1_out, port1_oe_out;
   logic [1:0]  grp5_out, grp5_oe_out, mode_out;
   int          fails = 0;
   int          n_checks = 0;
   int          cyc = 0;
   localparam logic [15:0] RA [14] = '{16'hFF60, 16'hFF61, 16'hFF62,
      16'hFF63, 16'hFF70, 16'hFF71, 16'hFF72, 16'hFF73, 16'hFF74,
      16'hFF75, 16'hFF76, 16'hFF77, 16'hFF78, 16'hFF7C};
   localparam logic [7:0] RV [14] = '{8'h00, 8'h00, 8'hFF, 8'hFF,
      8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h02, 8'h00};

   // factory bus mode kept at the recommended expanded 512K maximum
   pbm_port_bank #(.MASK_MODE(2'h3)) DUT (
      .clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
      .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .ext_prog_in,
      .port0_pin_in, .port1_pin_in, .port0_out, .port0_oe_out,
      .port1_out, .port1_oe_out, .rout_out, .rout_oe_out, .grp5_out,
      .grp5_oe_out, .mode_out);
   pbm_pins_model board (
      .port0_out_in(port0_out), .port0_oe_in(port0_oe_out),
      .port1_out_in(port1_out), .port1_oe_in(port1_oe_out),
      .rout_in(rout_out), .board_in(board_lvl),
      .port0_pin_out(port0_pin_in), .port1_pin_out(port1_pin_in));

   always #50 clk_in = ~clk_in;

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic results;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         results();
      end
   end

   task automatic chk(input logic [32:0] g, input logic [32:0] x);
      n_checks++;
      if (g !== x) begin
         fails++;
         $display("BAD %0t got %h want %h", $time, g, x);
      end
   endtask

   task automatic apb(input logic w, input logic [15:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      @(posedge clk_in);
      psel_in    <= 1'h1;
      penable_in <= 1'h0;
      pwrite_in  <= w;
      paddr_in   <= a;
      pwdata_in  <= d;
      @(posedge clk_in);
      penable_in <= 1'h1;
      do @(posedge clk_in); while (pready_out !== 1'h1);
      q = prdata_out;
      e = pslverr_out;
      psel_in    <= 1'h0;
      penable_in <= 1'h0;
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'h1, a, d, q, e);
   endtask

   task automatic rdc(input logic [15:0] a, input logic [31:0] x);
      logic [31:0] q;
      logic        e;
      apb(1'h0, a, 32'h0, q, e);
      chk({e, q}, {1'h0, x});
   endtask

   task automatic rst(input logic ext);
      ext_prog_in <= ext;
      rstn_in     <= 1'h0;
      repeat (8) @(posedge clk_in);
      rstn_in <= 1'h1;
      repeat (6) @(posedge clk_in);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      for (int i = 0; i < 14; i++)
         rdc(RA[i], {24'h0, RV[i]});
      chk({rout_out, rout_oe_out}, {32'hFFFFFFFF, 32'hFFFFFFFF});
      chk({grp5_out, grp5_oe_out, port0_oe_out, port1_oe_out, mode_out},
          {2'h2, 2'h3, 8'h00, 8'h00, 2'h0});
   endtask

   task automatic t_rw;
      logic [7:0]  v;
      logic [31:0] q;
      logic        e;
      for (int i = 0; i < 13; i++) begin
         if (i == 2 || i == 3)
            continue;
         v = 8'hA5 ^ i[7:0];
         wr(RA[i], {24'hFFFFFF, v});
         rdc(RA[i], {24'h0, (i == 12) ? (v & 8'h03) : v});
      end
      wr(16'hFF79, 32'hFF);
      rdc(16'hFF78, 32'h1);
      apb(1'h0, 16'hFF64, 32'h0, q, e);
      chk({e, q}, {1'h1, 32'h0});
   endtask

   task automatic t_ports;
      board_lvl <= 16'h3CC3;
      wr(16'hFF60, 32'h0F);
      wr(16'hFF62, 32'hA5);
      wr(16'hFF61, 32'hF0);
      wr(16'hFF63, 32'h5A);
      repeat (4) @(posedge clk_in);
      chk({port0_out[3:0], port0_oe_out, port1_out[7:4], port1_oe_out},
          {4'h5, 8'h0F, 4'h5, 8'hF0});
      rdc(16'hFF62, 32'hC5);
      rdc(16'hFF63, 32'h5C);
   endtask

   task automatic t_float;
      wr(16'hFF70, 32'h05);
      wr(16'hFF71, 32'h81);
      wr(16'hFF72, 32'h01);
      wr(16'hFF73, 32'h12);
      wr(16'hFF74, 32'h34);
      wr(16'hFF75, 32'h5E);
      wr(16'hFF76, 32'h78);
      wr(16'hFF78, 32'h01);
      repeat (2) @(posedge clk_in);
      chk(rout_oe_out, 32'hFE7EF0F0);
      chk(rout_out & rout_oe_out, 32'h785E3010);
      chk({grp5_out, grp5_oe_out}, {2'h1, 2'h3});
      wr(16'hFF70, 32'hC5);
      repeat (2) @(posedge clk_in);
      chk(grp5_oe_out, 2'h0);
   endtask

   task automatic t_modes;
      logic e;
      logic b;
      wr(16'hFF80, 32'h5A5A5);
      for (int m = 0; m < 4; m++) begin
         wr(16'hFF7C, m);
         repeat (2) @(posedge clk_in);
         e = (m != 0);
         b = (m >= 2);
         chk(mode_out, m);
         chk(rout_oe_out[18:0],
             {b ? 3'h7 : 3'h6, e ? 16'hFFFF : 16'hF0F0});
         chk(rout_out[18:0] & rout_oe_out[18:0],
             {b ? 3'h5 : 3'h6, e ? 16'hA5A5 : 16'h3010});
         chk(port0_oe_out, e ? 8'h00 : 8'h0F);
      end
      wr(16'hFF84, 32'hC306);
      repeat (2) @(posedge clk_in);
      chk({rout_out[20:19], port0_oe_out, port0_out},
          {2'h1, 8'hFF, 8'hC3});
      wr(16'hFF84, 32'hC304);
      wr(16'hFF84, 32'h0001);
      repeat (4) @(posedge clk_in);
      chk(rout_out[20:19], 2'h2);
      rdc(16'hFF84, 32'hC3);
      wr(16'hFF84, 32'h0);
   endtask

   task automatic t_strap;
      rst(1'h1);
      chk(mode_out, 2'h3);
      wr(16'hFF7C, 32'h0);
      repeat (2) @(posedge clk_in);
      chk(mode_out, 2'h3);
      wr(16'hFF7C, 32'h2);
      repeat (2) @(posedge clk_in);
      chk(mode_out, 2'h2);
   endtask

   initial begin
      rst(1'h0);
      t_reset();
      t_rw();
      t_ports();
      t_float();
      t_modes();
      t_strap();
      results();
   end
endmodule
